// file: uhc_pkg.sv
// uhc_pkg: shared constants, types and decode for the hex up/down counter
package uhc_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int COUNT_W = 4;
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 32;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_PRESET = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_SEL_LO_BIT  = 0;
	localparam int CTRL_SEL_HI_BIT  = 1;
	localparam int CTRL_SRC_PIN_BIT = 2;
	localparam int CTRL_CIN_B_BIT   = 3;
	localparam int STAT_COUNT_LSB   = 0;
	localparam int STAT_COUT_B_BIT  = 4;
	localparam int STAT_MODE_LSB    = 5;
	localparam int STAT_WRAP_BIT    = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [COUNT_W-1:0] COUNT_RESET  = 4'h0;
	localparam logic [COUNT_W-1:0] PRESET_RESET = 4'h0;

	// ----------------------------------------
	// bus responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_PRESET,
		MODE_UP,
		MODE_DOWN,
		MODE_HOLD
	} uhc_mode_t;

	typedef struct packed {
		logic carryInB;
		logic srcPins;
		logic modeSelectHi;
		logic modeSelectLo;
	} uhc_ctrl_t;

	localparam uhc_ctrl_t CTRL_RESET = '{carryInB: 1'b0, srcPins: 1'b0, modeSelectHi: 1'b1, modeSelectLo: 1'b1};

	// two select lines pick the operation; both high holds
	function automatic uhc_mode_t uhcDecodeMode(input logic selHi, input logic selLo);
		uhc_mode_t m;
		m = MODE_HOLD;
		unique case ({selHi, selLo})
			2'h0: m = MODE_PRESET;
			2'h1: m = MODE_UP;
			2'h2: m = MODE_DOWN;
			2'h3: m = MODE_HOLD;
		endcase
		return m;
	endfunction

endpackage

// file: uhc_count_core.sv
// uhc_count_core: the 4-bit synchronous preset/up/down/hold counter
`timescale 1ns/10ps
`default_nettype none

module uhc_count_core
	import uhc_pkg::*;
#(
	parameter int WIDTH = COUNT_W
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             modeSelectHi,
	input  wire logic             modeSelectLo,
	input  wire logic [WIDTH-1:0] presetBits,
	input  wire logic             carryInB,
	output var  logic [WIDTH-1:0] countBits,
	output var  logic             carryOutB,
	output var  logic             wrapPulse
);

	// ----------------------------------------
	// mode decode and next count
	// ----------------------------------------
	uhc_mode_t        mode;
	logic [WIDTH-1:0] countReg;
	logic [WIDTH-1:0] countNext;
	logic             atTopCount;
	logic             atBottomCount;
	logic             countAllowed;
	logic             terminal;

	assign mode          = uhcDecodeMode(modeSelectHi, modeSelectLo);
	assign atTopCount    = (countReg == {WIDTH{1'b1}});
	assign atBottomCount = (countReg == {WIDTH{1'b0}});
	// a high carry-in blocks counting only; preset and hold ignore it
	assign countAllowed  = ~carryInB;
	assign terminal      = ((mode == MODE_UP) && atTopCount) || ((mode == MODE_DOWN) && atBottomCount);

	always_comb begin
		countNext = countReg;
		unique case (mode)
			MODE_PRESET: countNext = presetBits;
			MODE_UP:     countNext = countAllowed ? WIDTH'(countReg + 1'b1) : countReg;
			MODE_DOWN:   countNext = countAllowed ? WIDTH'(countReg - 1'b1) : countReg;
			MODE_HOLD:   countNext = countReg;
		endcase
	end

	// ----------------------------------------
	// state: changes only at the rising edge, or at once when rst_b falls
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			countReg <= COUNT_RESET;
		end else begin
			countReg <= countNext;
		end
	end

	// carry-in gates the carry-out so stages cascade with no extra gates
	assign carryOutB = ~((mode == MODE_PRESET) || (terminal && countAllowed));
	assign countBits = countReg;
	assign wrapPulse = terminal && countAllowed;

endmodule

`default_nettype wire

// file: uhc_counter_top.sv
// uhc_counter_top: AXI4-Lite register front end around the hex counter core
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - selects pick preset, up, down or hold
// - selects alone fix the mode; carry-in does not
// - preset loads data only at clock edge
// - carry-out low at terminal with carry-in low, or at preset
// - all changes on rising clock edge, except the asynchronous reset when rst_b falls
// - high carry-in freezes up/down counting
module uhc_counter_top
	import uhc_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst_b,
	// counter pins, from logic on the same clock
	input  wire logic               modeSelectHi,
	input  wire logic               modeSelectLo,
	input  wire logic [COUNT_W-1:0] presetBits,
	input  wire logic               carryInB,
	output var  logic [COUNT_W-1:0] countBits,
	output var  logic               carryOutB,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]         s_axi_awprot,
	input  wire logic               s_axi_awvalid,
	output var  logic               s_axi_awready,
	input  wire logic [DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output var  logic               s_axi_wready,
	output var  logic [1:0]         s_axi_bresp,
	output var  logic               s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]         s_axi_arprot,
	input  wire logic               s_axi_arvalid,
	output var  logic               s_axi_arready,
	output var  logic [DATA_W-1:0]  s_axi_rdata,
	output var  logic [1:0]         s_axi_rresp,
	output var  logic               s_axi_rvalid,
	input  wire logic               s_axi_rready
);

	// ----------------------------------------
	// register state
	// ----------------------------------------
	uhc_ctrl_t          ctrl_reg;
	uhc_ctrl_t          ctrl_next;
	logic [COUNT_W-1:0] preset_reg;
	logic [COUNT_W-1:0] preset_next;
	logic               wrapSeen_reg;
	logic               wrapSeen_next;

	// ----------------------------------------
	// write and read channel holding state
	// ----------------------------------------
	logic               awHeld_reg;
	logic [ADDR_W-1:0]  awAddr_reg;
	logic               wHeld_reg;
	logic [DATA_W-1:0]  wData_reg;
	logic [3:0]         wStrb_reg;
	logic               bValid_reg;
	logic [1:0]         bResp_reg;
	logic               rValid_reg;
	logic [DATA_W-1:0]  rData_reg;
	logic [1:0]         rResp_reg;

	logic               awFire;
	logic               wFire;
	logic               arFire;
	logic               doWrite;
	logic               wrCtrl;
	logic               wrPreset;
	logic               wrStatus;
	logic               wrMapped;
	logic               rdMapped;
	logic [DATA_W-1:0]  rdWord;

	// ----------------------------------------
	// counter sources: pins or registers
	// ----------------------------------------
	logic               selHiUsed;
	logic               selLoUsed;
	logic [COUNT_W-1:0] presetUsed;
	logic               carryInUsed;
	logic               wrapPulse;
	uhc_mode_t          modeNow;

	// software may only drive the same controls the pins do, so the mode
	// still comes from the selects alone, whether the pins or the registers drive them
	assign selHiUsed   = ctrl_reg.srcPins ? modeSelectHi : ctrl_reg.modeSelectHi;
	assign selLoUsed   = ctrl_reg.srcPins ? modeSelectLo : ctrl_reg.modeSelectLo;
	assign presetUsed  = ctrl_reg.srcPins ? presetBits   : preset_reg;
	// carry-in always honours the pin so a cascade works in either source mode
	assign carryInUsed = carryInB | ctrl_reg.carryInB;
	assign modeNow     = uhcDecodeMode(selHiUsed, selLoUsed);

	uhc_count_core #(
		.WIDTH (COUNT_W)
	) u_core (
		.clock        (clock),
		.rst_b        (rst_b),
		.modeSelectHi (selHiUsed),
		.modeSelectLo (selLoUsed),
		.presetBits   (presetUsed),
		.carryInB     (carryInUsed),
		.countBits    (countBits),
		.carryOutB    (carryOutB),
		.wrapPulse    (wrapPulse)
	);

	// ----------------------------------------
	// write path decode
	// ----------------------------------------
	assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
	assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;
	assign awFire        = s_axi_awvalid & s_axi_awready;
	assign wFire         = s_axi_wvalid & s_axi_wready;
	// address and data are taken in either order; the write lands once both are in
	assign doWrite       = awHeld_reg & wHeld_reg & ~bValid_reg;
	assign wrCtrl        = doWrite & (awAddr_reg == OFS_CTRL);
	assign wrPreset      = doWrite & (awAddr_reg == OFS_PRESET);
	assign wrStatus      = doWrite & (awAddr_reg == OFS_STATUS);
	assign wrMapped      = (awAddr_reg == OFS_CTRL) | (awAddr_reg == OFS_PRESET) | (awAddr_reg == OFS_STATUS);

	// byte lane 0 carries the control and preset fields; lane 1 carries the wrap clear
	assign ctrl_next = (wrCtrl & wStrb_reg[0]) ? uhc_ctrl_t'(wData_reg[CTRL_CIN_B_BIT:CTRL_SEL_LO_BIT]) : ctrl_reg;
	assign preset_next = (wrPreset & wStrb_reg[0]) ? wData_reg[COUNT_W-1:0] : preset_reg;
	// set wins over a write-one-to-clear in the same cycle
	assign wrapSeen_next = wrapPulse |
		(wrapSeen_reg & ~(wrStatus & wStrb_reg[1] & wData_reg[STAT_WRAP_BIT]));

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg     <= CTRL_RESET;
			preset_reg   <= PRESET_RESET;
			wrapSeen_reg <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			preset_reg   <= preset_next;
			wrapSeen_reg <= wrapSeen_next;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= '0;
		end else if (awFire) begin
			awHeld_reg <= 1'b1;
			awAddr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
		end else if (doWrite) begin
			awHeld_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wHeld_reg <= 1'b0;
			wData_reg <= '0;
			wStrb_reg <= 4'h0;
		end else if (wFire) begin
			wHeld_reg <= 1'b1;
			wData_reg <= s_axi_wdata;
			wStrb_reg <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bValid_reg <= 1'b0;
			bResp_reg  <= RESP_OKAY;
		end else if (doWrite) begin
			bValid_reg <= 1'b1;
			bResp_reg  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp  = bResp_reg;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	assign s_axi_arready = ~rValid_reg;
	assign arFire        = s_axi_arvalid & s_axi_arready;

	logic [ADDR_W-1:0] rdAddr;
	logic [DATA_W-1:0] ctrlWord;
	logic [DATA_W-1:0] presetWord;
	logic [DATA_W-1:0] statusWord;

	assign rdAddr     = {s_axi_araddr[ADDR_W-1:2], 2'h0};
	assign ctrlWord   = {{(DATA_W-4){1'b0}}, ctrl_reg};
	assign presetWord = {{(DATA_W-COUNT_W){1'b0}}, preset_reg};
	// status shows the live count, carry-out and decoded mode
	assign statusWord = {{(DATA_W-9){1'b0}}, wrapSeen_reg, 1'b0, modeNow, carryOutB, countBits};
	assign rdMapped   = (rdAddr == OFS_CTRL) | (rdAddr == OFS_PRESET) | (rdAddr == OFS_STATUS);
	assign rdWord     = (rdAddr == OFS_CTRL)   ? ctrlWord :
	                    (rdAddr == OFS_PRESET) ? presetWord :
	                    (rdAddr == OFS_STATUS) ? statusWord : '0;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rValid_reg <= 1'b0;
			rData_reg  <= '0;
			rResp_reg  <= RESP_OKAY;
		end else if (arFire) begin
			rValid_reg <= 1'b1;
			rData_reg  <= rdWord;
			rResp_reg  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata  = rData_reg;
	assign s_axi_rresp  = rResp_reg;

	// prot is accepted but carries no meaning here
	logic unusedProt;
	assign unusedProt = ^{s_axi_awprot, s_axi_arprot, s_axi_awaddr[1:0], s_axi_araddr[1:0]};

endmodule

`default_nettype wire

// file: uhc_checker.sv
// uhc_checker: concurrent checks on the counter pins and bus answers
`timescale 1ns/10ps
`default_nettype none
module uhc_checker
	import uhc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic modeSelectHi,
	input wire logic modeSelectLo,
	input wire logic [COUNT_W-1:0] presetBits,
	input wire logic carryInB,
	input wire logic [COUNT_W-1:0] countBits,
	input wire logic carryOutB,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid
);
	// shadow of the control register, so pin or software selects can be told apart
	logic [3:0] ctrlSh_reg;
	logic [3:0] ctrlPend_reg;
	logic pend_reg;
	// shadow of the preset register, the load source while software owns the selects
	logic [COUNT_W-1:0] presetSh_reg;
	logic presetPend_reg;
	logic [3:0] negCnt_reg;
	wire wTake = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrlSh_reg <= CTRL_RESET;
			ctrlPend_reg <= 4'h0;
			pend_reg <= 1'b0;
			presetSh_reg <= PRESET_RESET;
			presetPend_reg <= 1'b0;
		end else begin
			pend_reg <= wTake && s_axi_awaddr[3:2] == 2'h0;
			presetPend_reg <= wTake && s_axi_awaddr[3:2] == 2'h1;
			ctrlPend_reg <= s_axi_wdata[3:0];
			if (pend_reg)
				ctrlSh_reg <= ctrlPend_reg;
			if (presetPend_reg)
				presetSh_reg <= ctrlPend_reg;
		end
	end
	always_ff @(negedge clock)
		negCnt_reg <= countBits;
	wire sHi = ctrlSh_reg[2] ? modeSelectHi : ctrlSh_reg[1];
	wire sLo = ctrlSh_reg[2] ? modeSelectLo : ctrlSh_reg[0];
	wire blk = carryInB | ctrlSh_reg[3];
	wire [COUNT_W-1:0] preSrc = ctrlSh_reg[2] ? presetBits : presetSh_reg;
	wire pre = !sHi && !sLo;
	wire up = !sHi && sLo && !blk;
	wire dn = sHi && !sLo && !blk;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	preset_load_a: assert property (pre |=> countBits == $past(preSrc))
		else $error("preset data not loaded");
	up_step_a: assert property (up |=> countBits == $past(countBits) + 4'h1)
		else $error("up count wrong");
	down_step_a: assert property (dn |=> countBits == $past(countBits) - 4'h1)
		else $error("down count wrong");
	count_freeze_a: assert property (!pre && !up && !dn |=> $stable(countBits))
		else $error("count moved while held or blocked");
	preset_carry_a: assert property (pre |-> !carryOutB)
		else $error("carry out high in preset");
	terminal_carry_a: assert property (carryOutB == !(pre || up && countBits == 4'hF || dn && countBits == 4'h0))
		else $error("carry out wrong");
	edge_only_a: assert property (countBits == negCnt_reg)
		else $error("count changed away from rising edge");
	read_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h3
		|=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answer wrong");
endmodule
bind uhc_counter_top uhc_checker chk_u (.clock(clock), .rst_b(rst_b), .modeSelectHi(modeSelectHi),
	.modeSelectLo(modeSelectLo), .presetBits(presetBits), .carryInB(carryInB), .countBits(countBits),
	.carryOutB(carryOutB), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// file: uhc_pin_drv.sv
// uhc_pin_drv: model of the system logic driving the counter pins
`timescale 1ns/10ps
`default_nettype none
module uhc_pin_drv
	import uhc_pkg::*;
(
	output var logic selHi,
	output var logic selLo,
	output var logic [COUNT_W-1:0] preset,
	output var logic cinB
);
	// the clock is never gated here; the mode changes only through the selects
	task automatic drive(input logic [6:0] v);
		{selHi, selLo, preset, cinB} <= v;
	endtask
	initial {selHi, selLo, preset, cinB} = 7'h7F;
endmodule
`default_nettype wire

// file: testbench.sv
// testbench: random and corner stimulus for the hex counter and its bus front end
`timescale 1ns/10ps
`default_nettype none
module testbench
	import uhc_pkg::*;
;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic hi, lo, cinB, cout, swBlk = 1'b0;
	logic wrapExp = 1'b0;
	logic [3:0] pre, cnt, ex = 4'h0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [6:0] cor [8] = '{7'h1E, 7'h20, 7'h21, 7'h01, 7'h40, 7'h41, 7'h20, 7'h60};
	int error_cnt = 0, n_compared = 0, cyc = 0;
	uhc_pin_drv pin_u (.selHi(hi), .selLo(lo), .preset(pre), .cinB(cinB));
	uhc_counter_top dut_u (.clock(clock), .rst_b(rst_b), .modeSelectHi(hi), .modeSelectLo(lo),
		.presetBits(pre), .carryInB(cinB), .countBits(cnt), .carryOutB(cout),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial forever #12.5 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// readies are looked at on the falling edge, where they equal what the next rising edge samples
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clock);
			aw = awvalid & awready;
			w = wvalid & wready;
			b = bvalid;
			r = bresp;
			@(posedge clock);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t, b;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clock);
			t = arvalid & arready;
			b = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clock);
			if (t) arvalid <= 1'b0;
		end while (!b);
		rready <= 1'b0;
	endtask
	// v packs {select hi, select lo, preset data, carry in}
	function automatic logic [3:0] nxt(input logic [6:0] v, input logic [3:0] c);
		case (v[6:5])
			2'h0: return v[4:1];
			2'h1: return v[0] ? c : c + 4'h1;
			2'h2: return v[0] ? c : c - 4'h1;
			default: return c;
		endcase
	endfunction
	function automatic logic cob(input logic [6:0] v, input logic [3:0] c);
		return !(v[6:5] == 2'h0 || !v[0] && (v[6:5] == 2'h1 && c == 4'hF || v[6:5] == 2'h2 && c == 4'h0));
	endfunction
	task automatic step(input logic [6:0] v);
		logic [6:0] vv;
		vv = v | {6'h0, swBlk};
		@(posedge clock);
		pin_u.drive(v);
		#1;
		chk(cnt, ex);
		chk(cout, cob(vv, ex));
		// a terminal count with carry enabled outside preset leaves the sticky wrap flag set
		if (vv[6:5] != 2'h0 && !cob(vv, ex))
			wrapExp = 1'b1;
		ex = nxt(vv, ex);
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		d = $urandom(32'h5C4B);
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rd(OFS_CTRL, d, r);
		chk(d, {28'h0, CTRL_RESET});
		rd(OFS_PRESET, d, r);
		chk(d, {28'h0, PRESET_RESET});
		rd(OFS_STATUS, d, r);
		chk(d, 32'h70);
		rd(4'hC, d, r);
		chk(d, 32'h0);
		chk(r, RESP_SLVERR);
		wr(4'hC, 32'h5, r);
		chk(r, RESP_SLVERR);
		// software source: selects and preset data come from the registers
		wr(OFS_PRESET, 32'h9, r);
		chk(r, RESP_OKAY);
		wr(OFS_CTRL, 32'h0, r);
		chk(r, RESP_OKAY);
		rd(OFS_STATUS, d, r);
		chk(d, 32'h9);
		wr(OFS_CTRL, 32'h3, r);
		chk(r, RESP_OKAY);
		rd(OFS_CTRL, d, r);
		chk(d, 32'h3);
		rd(OFS_STATUS, d, r);
		chk(d, 32'h79);
		ex = 4'h9;
		wr(OFS_CTRL, 32'h4, r);
		chk(r, RESP_OKAY);
		foreach (cor[i])
			step(cor[i]);
		repeat (300)
			step(7'($urandom));
		step(7'h7F);
		rd(OFS_STATUS, d, r);
		chk(d, {23'h0, wrapExp, 4'h7, ex});
		wr(OFS_STATUS, 32'h100, r);
		chk(r, RESP_OKAY);
		rd(OFS_STATUS, d, r);
		chk(d, {24'h0, 4'h7, ex});
		// software carry block ors with the pin and must freeze up and down counting
		wr(OFS_CTRL, 32'hC, r);
		chk(r, RESP_OKAY);
		swBlk = 1'b1;
		repeat (20)
			step(7'($urandom));
		end_sim();
	end
endmodule
`default_nettype wire
